//--- pkg/elg_regs.vh
// Subaddresses, field positions and reset values of the level and gain register bank
`ifndef ELG_REGS_VH
`define ELG_REGS_VH

// ****************************************************************
// Subaddresses
// ****************************************************************
`define ELG_ADDR_LINE16_BYTE14    8'h59
`define ELG_ADDR_SUBCARRIER_PHASE 8'h5A
`define ELG_ADDR_BLUE_GAIN_LOW    8'h5B
`define ELG_ADDR_RED_GAIN_LOW     8'h5C
`define ELG_ADDR_BLUE_MSB_BLACK   8'h5D
`define ELG_ADDR_RED_MSB_BLANK    8'h5E
`define ELG_ADDR_XCOLOUR_VBLANK   8'h5F

// ****************************************************************
// Field positions
// ****************************************************************
`define ELG_GAIN_TOP_BIT     7
`define ELG_ACCEPT_EN_BIT    6
`define ELG_LEVEL_MSB        5
`define ELG_LEVEL_LSB        0
`define ELG_XCOLOUR_MSB      7
`define ELG_XCOLOUR_LSB      6

// ****************************************************************
// Reset values
// ****************************************************************
`define ELG_RST_LINE16_BYTE14    8'h00
`define ELG_RST_SUBCARRIER_PHASE 8'h00
`define ELG_RST_BLUE_GAIN_LOW    8'h00
`define ELG_RST_RED_GAIN_LOW     8'h00
`define ELG_RST_BLUE_MSB_BLACK   8'h00
`define ELG_RST_RED_MSB_BLANK    8'h35
`define ELG_RST_XCOLOUR_VBLANK   8'h00

// ****************************************************************
// Serial output of the line 16 byte
// ****************************************************************
`define ELG_LINE16_BITS          4'h8

`endif

//--- verilog/elg_level_gain_regs.v
// Level, chroma gain and subcarrier phase register bank of the video encoder
//
// Contract
// R1 - Subaddress 59H holds the fourteenth line-16 data byte, sent out least significant bit first.
// R2 - The 8-bit phase code offsets the colour subcarrier and burst from horizontal sync, 360/256 degrees per step.
// R3 - Software loads the phase code with 0FH, 3AH, 35H or 57H according to standard and data source.
// R4 - The 9-bit blue gain takes its low byte from 5BH and its top bit from bit 7 of 5DH.
// R5 - The 9-bit red gain takes its low byte from 5CH and its top bit from bit 7 of 5EH.
// R6 - A blue gain of zero gives zero U output; 118, 125 and 106 are the nominal codes.
// R7 - A red gain of zero gives zero V output; 165, 175 and 129 are the nominal codes.
// R8 - With the field accept enable set the odd/even bit of the control input is used, else ignored.
// R9 - With the phase reset accept enable set the control input's phase reset is obeyed, else ignored.
// R10 - The 6-bit black level code sets the black level linearly.
// R11 - Software loads the black level code with 58 or 51 according to scaling.
// R12 - The 6-bit blanking level code in bits 5 to 0 sets the blanking level from 25 to 45 IRE.
// R13 - The blanking level code is 35H after reset.
// R14 - A separate 6-bit code sets the blanking level during vertical blanking.
// R15 - The 2-bit filter select in bits 7 and 6 turns off or picks one of three cross-colour filters.
// R16 - Each 9-bit chroma gain is applied as a signed two's-complement multiplier.
`include "elg_regs.vh"
`default_nettype none

module elg_level_gain_regs #(
   parameter CHROMA_W = 8
) (
   input  wire                       ref_clk,
   input  wire                       rst,
   // Subaddress write and read from the serial bus slave
   input  wire                       wr_en,
   input  wire                       rd_en,
   input  wire [7:0]                 subaddr,
   input  wire [7:0]                 wr_data,
   output reg  [7:0]                 rd_data,
   output reg                        rd_hit,
   // Line 16 data insertion
   input  wire                       line16_load,
   input  wire                       line16_shift,
   output reg                        line16_bit_out,
   output wire                       line16_busy,
   // Subcarrier phase
   input  wire [7:0]                 subcarrier_phase_in,
   output reg  [7:0]                 subcarrier_phase_out,
   output wire [7:0]                 subcarrier_phase_code,
   // Chroma gain datapath
   input  wire                       chroma_valid_in,
   input  wire signed [CHROMA_W-1:0] chroma_u_in,
   input  wire signed [CHROMA_W-1:0] chroma_v_in,
   output reg                        chroma_valid_out,
   output reg  signed [CHROMA_W+8:0] chroma_u_out,
   output reg  signed [CHROMA_W+8:0] chroma_v_out,
   output wire [8:0]                 blue_chroma_gain,
   output wire [8:0]                 red_chroma_gain,
   // Real-time control input pins
   input  wire                       realtime_control_input_field,
   input  wire                       realtime_control_input_phase_reset,
   output reg                        field_odd_even,
   output reg                        subcarrier_phase_reset,
   output wire                       field_bit_accept_en,
   output wire                       phase_reset_accept_en,
   // Levels and cross-colour filter
   input  wire                       vblank,
   output wire [5:0]                 black_level_code,
   output wire [5:0]                 blanking_level_code,
   output wire [5:0]                 vblank_level_code,
   output reg  [5:0]                 blank_level_active,
   output wire [1:0]                 xcolour_filter_sel,
   output wire                       xcolour_reduction_on
);

   // ****************************************************************
   // Register storage
   // ****************************************************************
   reg [7:0] line16_byte_fourteen_reg;
   reg [7:0] subcarrier_phase_reg;
   reg [7:0] blue_gain_low_reg;
   reg [7:0] red_gain_low_reg;
   reg [7:0] blue_gain_msb_black_level_reg;
   reg [7:0] red_gain_msb_blank_level_reg;
   reg [7:0] crosscolour_vblank_level_reg;

   always @(posedge ref_clk) begin
      if (rst) begin
         line16_byte_fourteen_reg      <= `ELG_RST_LINE16_BYTE14;
         subcarrier_phase_reg          <= `ELG_RST_SUBCARRIER_PHASE;
         blue_gain_low_reg             <= `ELG_RST_BLUE_GAIN_LOW;
         red_gain_low_reg              <= `ELG_RST_RED_GAIN_LOW;
         blue_gain_msb_black_level_reg <= `ELG_RST_BLUE_MSB_BLACK;
         red_gain_msb_blank_level_reg  <= `ELG_RST_RED_MSB_BLANK; // R13
         crosscolour_vblank_level_reg  <= `ELG_RST_XCOLOUR_VBLANK;
      end else if (wr_en) begin
         // Writes to subaddresses outside this slice are left to other banks
         if (subaddr == `ELG_ADDR_LINE16_BYTE14) begin
            line16_byte_fourteen_reg <= wr_data;
         end else if (subaddr == `ELG_ADDR_SUBCARRIER_PHASE) begin
            subcarrier_phase_reg <= wr_data;
         end else if (subaddr == `ELG_ADDR_BLUE_GAIN_LOW) begin
            blue_gain_low_reg <= wr_data;
         end else if (subaddr == `ELG_ADDR_RED_GAIN_LOW) begin
            red_gain_low_reg <= wr_data;
         end else if (subaddr == `ELG_ADDR_BLUE_MSB_BLACK) begin
            blue_gain_msb_black_level_reg <= wr_data;
         end else if (subaddr == `ELG_ADDR_RED_MSB_BLANK) begin
            red_gain_msb_blank_level_reg <= wr_data;
         end else if (subaddr == `ELG_ADDR_XCOLOUR_VBLANK) begin
            crosscolour_vblank_level_reg <= wr_data;
         end
      end
   end

   // ****************************************************************
   // Read back
   // ****************************************************************
   always @(posedge ref_clk) begin
      if (rst) begin
         rd_data <= 8'h00;
         rd_hit  <= 1'b0;
      end else if (rd_en) begin
         rd_hit <= 1'b1;
         if (subaddr == `ELG_ADDR_LINE16_BYTE14) begin
            rd_data <= line16_byte_fourteen_reg;
         end else if (subaddr == `ELG_ADDR_SUBCARRIER_PHASE) begin
            rd_data <= subcarrier_phase_reg;
         end else if (subaddr == `ELG_ADDR_BLUE_GAIN_LOW) begin
            rd_data <= blue_gain_low_reg;
         end else if (subaddr == `ELG_ADDR_RED_GAIN_LOW) begin
            rd_data <= red_gain_low_reg;
         end else if (subaddr == `ELG_ADDR_BLUE_MSB_BLACK) begin
            rd_data <= blue_gain_msb_black_level_reg;
         end else if (subaddr == `ELG_ADDR_RED_MSB_BLANK) begin
            rd_data <= red_gain_msb_blank_level_reg;
         end else if (subaddr == `ELG_ADDR_XCOLOUR_VBLANK) begin
            rd_data <= crosscolour_vblank_level_reg;
         end else begin
            // Unmapped subaddress: zero, and no hit so another bank may answer
            rd_data <= 8'h00;
            rd_hit  <= 1'b0;
         end
      end else begin
         rd_hit <= 1'b0;
      end
   end

   // ****************************************************************
   // Field decode
   // ****************************************************************
   assign subcarrier_phase_code = subcarrier_phase_reg;
   assign blue_chroma_gain      = {blue_gain_msb_black_level_reg[`ELG_GAIN_TOP_BIT],
                                   blue_gain_low_reg}; // R4
   assign red_chroma_gain       = {red_gain_msb_blank_level_reg[`ELG_GAIN_TOP_BIT],
                                   red_gain_low_reg}; // R5
   assign field_bit_accept_en   = blue_gain_msb_black_level_reg[`ELG_ACCEPT_EN_BIT];
   assign phase_reset_accept_en = red_gain_msb_blank_level_reg[`ELG_ACCEPT_EN_BIT];
   assign black_level_code      =
      blue_gain_msb_black_level_reg[`ELG_LEVEL_MSB:`ELG_LEVEL_LSB]; // R10
   assign blanking_level_code   =
      red_gain_msb_blank_level_reg[`ELG_LEVEL_MSB:`ELG_LEVEL_LSB]; // R12
   assign vblank_level_code     =
      crosscolour_vblank_level_reg[`ELG_LEVEL_MSB:`ELG_LEVEL_LSB]; // R14
   assign xcolour_filter_sel    =
      crosscolour_vblank_level_reg[`ELG_XCOLOUR_MSB:`ELG_XCOLOUR_LSB]; // R15
   assign xcolour_reduction_on  = |xcolour_filter_sel; // R15

   // ****************************************************************
   // Line 16 byte, serial out
   // ****************************************************************
   reg [7:0] line16_shift_reg;
   reg [3:0] line16_count_reg;

   assign line16_busy = (line16_count_reg != 4'h0);

   always @(posedge ref_clk) begin
      if (rst) begin
         line16_shift_reg <= 8'h00;
         line16_count_reg <= 4'h0;
         line16_bit_out   <= 1'b0;
      end else if (line16_load) begin
         // Snapshot so a host write mid-line cannot tear the byte
         line16_shift_reg <= line16_byte_fourteen_reg;
         line16_count_reg <= `ELG_LINE16_BITS;
      end else if (line16_shift && line16_busy) begin
         line16_bit_out   <= line16_shift_reg[0]; // R1
         line16_shift_reg <= {1'b0, line16_shift_reg[7:1]}; // R1
         line16_count_reg <= line16_count_reg - 4'h1;
      end
   end

   // ****************************************************************
   // Subcarrier phase offset
   // ****************************************************************
   always @(posedge ref_clk) begin
      if (rst) begin
         subcarrier_phase_out <= 8'h00;
      end else begin
         // Modulo 256 wraps exactly one turn of 360 degrees
         subcarrier_phase_out <= subcarrier_phase_in + subcarrier_phase_reg; // R2
      end
   end

   // ****************************************************************
   // Chroma gain
   // ****************************************************************
   wire signed [8:0] blue_gain_signed = $signed(blue_chroma_gain); // R16
   wire signed [8:0] red_gain_signed  = $signed(red_chroma_gain); // R16

   always @(posedge ref_clk) begin
      if (rst) begin
         chroma_valid_out <= 1'b0;
         chroma_u_out     <= {(CHROMA_W+9){1'b0}};
         chroma_v_out     <= {(CHROMA_W+9){1'b0}};
      end else begin
         chroma_valid_out <= chroma_valid_in;
         // Full-width product: gain zero gives exactly zero, no rounding term
         chroma_u_out     <= chroma_u_in * blue_gain_signed; // R6
         chroma_v_out     <= chroma_v_in * red_gain_signed; // R7
      end
   end

   // ****************************************************************
   // Real-time control input
   // ****************************************************************
   reg [1:0] field_sync_reg;
   reg [1:0] phase_reset_sync_reg;
   reg       phase_reset_seen_reg;

   always @(posedge ref_clk) begin
      if (rst) begin
         field_sync_reg         <= 2'b00;
         phase_reset_sync_reg   <= 2'b00;
         phase_reset_seen_reg   <= 1'b0;
         field_odd_even         <= 1'b0;
         subcarrier_phase_reset <= 1'b0;
      end else begin
         field_sync_reg       <= {field_sync_reg[0], realtime_control_input_field};
         phase_reset_sync_reg <= {phase_reset_sync_reg[0], realtime_control_input_phase_reset};
         phase_reset_seen_reg <= phase_reset_sync_reg[1];
         // Disabled: hold the last accepted field so the datapath keeps its own count
         if (field_bit_accept_en) begin
            field_odd_even <= field_sync_reg[1]; // R8
         end
         subcarrier_phase_reset <= phase_reset_accept_en &&
                                   phase_reset_sync_reg[1] && !phase_reset_seen_reg; // R9
      end
   end

   // ****************************************************************
   // Blanking level in use
   // ****************************************************************
   always @(posedge ref_clk) begin
      if (rst) begin
         blank_level_active <= 6'h00;
      end else if (vblank) begin
         blank_level_active <= vblank_level_code; // R14
      end else begin
         blank_level_active <= blanking_level_code; // R12
      end
   end

endmodule

`default_nettype wire

//--- dv/elg_host_model.sv
// Serial-bus host model issuing subaddress writes and reads
`default_nettype none
module elg_host_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_hit,
   output var  logic       wr_en,
   output var  logic       rd_en,
   output var  logic [7:0] subaddr,
   output var  logic [7:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      subaddr = 8'h00;
      wr_data = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr_en <= 1'b1;
      subaddr <= a;
      wr_data <= d;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      // Released lines flip so a stale value never passes for a fresh one
      subaddr <= ~a;
      wr_data <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(posedge ref_clk);
      rd_en <= 1'b1;
      subaddr <= a;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      subaddr <= ~a;
      #1;
      d = rd_data;
      h = rd_hit;
   endtask
endmodule
`default_nettype wire

//--- dv/elg_level_gain_regs_chk.sv
// Port assertions of the level and gain register bank
`default_nettype none
module elg_level_gain_regs_chk #(
   parameter CHROMA_W = 8
) (
   input wire logic                       ref_clk,
   input wire logic                       rst,
   input wire logic                       wr_en,
   input wire logic [7:0]                 subaddr,
   input wire logic [7:0]                 wr_data,
   input wire logic [7:0]                 subcarrier_phase_in,
   input wire logic [7:0]                 subcarrier_phase_out,
   input wire logic [7:0]                 subcarrier_phase_code,
   input wire logic                       chroma_valid_in,
   input wire logic signed [CHROMA_W-1:0] chroma_u_in,
   input wire logic                       chroma_valid_out,
   input wire logic signed [CHROMA_W+8:0] chroma_u_out,
   input wire logic [8:0]                 blue_chroma_gain,
   input wire logic [8:0]                 red_chroma_gain,
   input wire logic                       field_odd_even,
   input wire logic                       field_bit_accept_en,
   input wire logic                       subcarrier_phase_reset,
   input wire logic                       phase_reset_accept_en,
   input wire logic                       vblank,
   input wire logic [5:0]                 blanking_level_code,
   input wire logic [5:0]                 vblank_level_code,
   input wire logic [5:0]                 blank_level_active,
   input wire logic [1:0]                 xcolour_filter_sel,
   input wire logic                       xcolour_reduction_on
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ****************************************************************
   // Assertions
   // ****************************************************************
   AST_BGAIN: assert property (wr_en && subaddr == 8'h5B |=>
      blue_chroma_gain[7:0] == $past(wr_data)) else $error("blue gain low byte lost");
   AST_RGAIN: assert property (wr_en && subaddr == 8'h5E |=>
      red_chroma_gain[8] == $past(wr_data[7])) else $error("red gain top bit lost");
   AST_PHASE: assert property (!$past(rst) |-> subcarrier_phase_out ==
      8'($past(subcarrier_phase_in) + $past(subcarrier_phase_code))) else $error("phase sum");
   AST_VALID: assert property (!$past(rst) |->
      chroma_valid_out == $past(chroma_valid_in)) else $error("chroma valid delay");
   AST_UOUT: assert property (chroma_valid_out |-> chroma_u_out ==
      $past(chroma_u_in) * $signed($past(blue_chroma_gain))) else $error("u product");
   AST_FIELD: assert property (!field_bit_accept_en |=> $stable(field_odd_even))
      else $error("field bit taken while disabled");
   AST_PHRST: assert property (subcarrier_phase_reset |->
      $past(phase_reset_accept_en) ##1 !subcarrier_phase_reset) else $error("phase reset pulse");
   AST_BLANK: assert property (!$past(rst) |-> blank_level_active ==
      $past(vblank ? vblank_level_code : blanking_level_code)) else $error("blank level");
   AST_XCOL: assert property (xcolour_reduction_on == (xcolour_filter_sel != 2'b00))
      else $error("filter enable");
   cover property (subcarrier_phase_reset);
   cover property (chroma_valid_out && blue_chroma_gain[8]);
   cover property (xcolour_filter_sel == 2'b11);
endmodule
bind elg_level_gain_regs elg_level_gain_regs_chk #(.CHROMA_W(CHROMA_W)) chk (.*);
`default_nettype wire

//--- dv/elg_level_gain_regs_bench.sv
// Self-checking bench of the level and gain register bank
`default_nettype none
module elg_level_gain_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst, line16_load, line16_shift, chroma_valid_in, vblank;
   logic realtime_control_input_field, realtime_control_input_phase_reset;
   logic [7:0] subcarrier_phase_in, b;
   logic signed [7:0] chroma_u_in, chroma_v_in;
   wire logic wr_en, rd_en, rd_hit, line16_bit_out, line16_busy, chroma_valid_out;
   wire logic field_odd_even, subcarrier_phase_reset, field_bit_accept_en;
   wire logic phase_reset_accept_en, xcolour_reduction_on;
   wire logic [7:0] subaddr, wr_data, rd_data, subcarrier_phase_out, subcarrier_phase_code;
   wire logic [16:0] chroma_u_out, chroma_v_out;
   wire logic [8:0] blue_chroma_gain, red_chroma_gain;
   wire logic [5:0] black_level_code, blanking_level_code, vblank_level_code, blank_level_active;
   wire logic [1:0] xcolour_filter_sel;
   integer mismatches, total_checks, seed, pulses, i;
   logic [7:0] rv [7];
   logic [7:0] pcs [4] = '{8'h0F, 8'h3A, 8'h35, 8'h57};
   logic [8:0] gb [5] = '{9'h000, 9'h076, 9'h07D, 9'h06A, 9'h1FF};
   logic [8:0] gr [5] = '{9'h000, 9'h0A5, 9'h0AF, 9'h081, 9'h100};
   elg_host_model host (.*);
   elg_level_gain_regs dut (.*);
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic hit);
      logic [7:0] d;
      logic       h;
      host.rd(a, d, h);
      chk(d, e);
      chk(h, hit);
   endtask
   function automatic [16:0] mul(input logic signed [7:0] s, input logic [8:0] g);
      mul = s * $signed(g);
   endfunction
   task automatic results;
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      vblank <= 1'($random(seed));
      if (subcarrier_phase_reset === 1'b1) pulses <= pulses + 1;
   end
   // A full run needs under 200 cycles; this leaves wide margin
   initial begin
      #100us;
      mismatches++;
      results();
   end
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      {seed, mismatches, total_checks, pulses} = {32'd36, 96'd0};
      {rst, line16_load, line16_shift, chroma_valid_in, vblank} = 5'b1_0000;
      {realtime_control_input_field, realtime_control_input_phase_reset} = 2'b00;
      {subcarrier_phase_in, chroma_u_in, chroma_v_in} = 24'h00_0000;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      for (i = 0; i < 7; i++) rdchk(8'(8'h59 + i), (i == 5) ? 8'h35 : 8'h00, 1'b1);
      rdchk(8'h60, 8'h00, 1'b0);
      for (i = 0; i < 7; i++) begin
         rv[i] = 8'($random(seed));
         host.wr(8'(8'h59 + i), rv[i]);
      end
      for (i = 0; i < 7; i++) rdchk(8'(8'h59 + i), rv[i], 1'b1);
      chk(blue_chroma_gain, {rv[4][7], rv[2]});
      chk(red_chroma_gain, {rv[5][7], rv[3]});
      chk({black_level_code, blanking_level_code}, {rv[4][5:0], rv[5][5:0]});
      chk({vblank_level_code, field_bit_accept_en}, {rv[6][5:0], rv[4][6]});
      chk(phase_reset_accept_en, rv[5][6]);
      @(posedge ref_clk);
      line16_load <= 1'b1;
      @(posedge ref_clk);
      line16_load <= 1'b0;
      line16_shift <= 1'b1;
      for (i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         #1 chk(line16_bit_out, rv[0][i]);
      end
      chk(line16_busy, 1'b0);
      for (i = 0; i < 4; i++) begin
         host.wr(8'h5A, pcs[i]);
         line16_shift <= 1'b0;
         b = 8'($random(seed));
         subcarrier_phase_in <= b;
         @(posedge ref_clk);
         #1 chk(subcarrier_phase_out, 8'(b + pcs[i]));
      end
      for (i = 0; i < 5; i++) begin
         host.wr(8'h5B, gb[i][7:0]);
         host.wr(8'h5D, {gb[i][8], 7'h3A});
         host.wr(8'h5C, gr[i][7:0]);
         host.wr(8'h5E, {gr[i][8], 7'h35});
         chroma_u_in <= 8'($random(seed));
         chroma_v_in <= 8'($random(seed));
         chroma_valid_in <= 1'b1;
         @(posedge ref_clk);
         chroma_valid_in <= 1'b0;
         #1 chk(chroma_u_out, mul(chroma_u_in, gb[i]));
         chk(chroma_v_out, mul(chroma_v_in, gr[i]));
         chk(chroma_valid_out, 1'b1);
      end
      for (i = 0; i < 4; i++) begin
         host.wr(8'h5F, {2'(i), 6'h2E});
         #1 chk({xcolour_filter_sel, xcolour_reduction_on}, {2'(i), i != 0});
      end
      host.wr(8'h5D, 8'h40);
      host.wr(8'h5E, 8'h35);
      realtime_control_input_field <= 1'b1;
      // Two sync stages and the output flop must pass before the enable drops
      repeat (3) @(posedge ref_clk);
      host.wr(8'h5D, 8'h00);
      #1 chk(field_odd_even, 1'b1);
      realtime_control_input_field <= 1'b0;
      repeat (6) @(posedge ref_clk);
      realtime_control_input_phase_reset <= 1'b1;
      #1 chk(field_odd_even, 1'b1);
      repeat (6) @(posedge ref_clk);
      realtime_control_input_phase_reset <= 1'b0;
      host.wr(8'h5E, 8'h75);
      realtime_control_input_phase_reset <= 1'b1;
      repeat (6) @(posedge ref_clk);
      #1 chk(pulses, 1);
      results();
   end
endmodule
`default_nettype wire
